// ---- rtl/ant_divider.sv ----
// Programmable divider of the antenna resonance, 16 to 128
`timescale 1ns/1ps
module ant_divider
    import tune_cal_pkg::*;
#(
    parameter int CNT_W = 6
)(
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    tune_cal_if.div   bus
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] half;
    logic             sq;
    logic             next_sq;
    logic             pulse;
    logic             next_pulse;

    // Half period in antenna cycles: 8, 16, 32, 64
    always_comb
    begin
        unique case (bus.ratio_sel)
            2'b00: half = CNT_W'(7);
            2'b01: half = CNT_W'(15);
            2'b10: half = CNT_W'(31);
            2'b11: half = CNT_W'(63);
        endcase
    end

    always_comb
    begin
        next_cnt   = cnt;
        next_sq    = sq;
        next_pulse = 1'b0;
        if (bus.ant_edge)
        begin
            if (cnt >= half)
            begin
                next_cnt   = '0;
                next_sq    = ~sq;
                next_pulse = ~sq;
            end
            else
            begin
                next_cnt = cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt   <= '0;
            sq    <= 1'b0;
            pulse <= 1'b0;
        end
        else
        begin
            cnt   <= next_cnt;
            sq    <= next_sq;
            pulse <= next_pulse;
        end
    end

    assign bus.div_out   = sq;
    assign bus.div_pulse = pulse;

    half_period_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (bus.ant_edge && cnt < half) |=> sq == $past(sq))
        else $error("divider output toggled early");
endmodule

// ---- rtl/tune_cal_ctrl.sv ----
// Antenna tuning, clock display on the interrupt pin and oscillator trim
`timescale 1ns/1ps
module tune_cal_ctrl
    import tune_cal_pkg::*;
#(
    parameter int CNT_W = 16
)(
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        calib_cmd_i,
    input  wire logic        ant_edge_i,
    input  wire logic        tmr_osc_i,
    input  wire logic        irq_event_i,
    input  wire logic [3:0]  irq_cause_i,
    output logic      [7:0]  reg_rdata_o,
    output logic      [3:0]  cap_sel_o,
    output logic             irq_o,
    output logic [TRIM_W-1:0] sys_trim_o,
    output logic [TRIM_W-1:0] tmr_trim_o,
    output logic             cal_busy_o
);
    tune_cal_if div_bus ();

    logic [7:0]        tune_reg, next_tune_reg;
    logic [7:0]        irq_reg, next_irq_reg;
    logic              irq_line, next_irq_line;
    logic [7:0]        rdata, next_rdata;
    logic              pin, next_pin;
    logic              sys_div, next_sys_div;
    logic              tmr_q;
    disp_sel_e         disp;

    cal_state_e        cal_st, next_cal_st;
    logic [CNT_W-1:0]  ant_cnt, next_ant_cnt;
    logic [CNT_W-1:0]  sys_cnt, next_sys_cnt;
    logic [CNT_W-1:0]  tmr_cnt, next_tmr_cnt;
    logic [TRIM_W-1:0] sys_trim, next_sys_trim;
    logic [TRIM_W-1:0] tmr_trim, next_tmr_trim;
    logic              tmr_rise;
    logic              busy, next_busy;

    ant_divider #(.CNT_W(6)) u_div (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .bus       (div_bus.div)
    );

    assign div_bus.ant_edge  = ant_edge_i;
    assign div_bus.ratio_sel = irq_reg[DIV_SEL_MSB:DIV_SEL_LSB];
    assign tmr_rise          = tmr_osc_i & ~tmr_q;

    // Display priority guards against several bits set at once
    always_comb
    begin
        if (tune_reg[ANT_DISP_BIT])
            disp = DISP_ANT;
        else if (tune_reg[SYS_DISP_BIT])
            disp = DISP_SYS;
        else if (tune_reg[TMR_DISP_BIT])
            disp = DISP_TMR;
        else
            disp = DISP_NONE;
    end

    // Register access and interrupt line
    always_comb
    begin
        next_tune_reg = tune_reg;
        next_irq_reg  = irq_reg;
        next_irq_line = irq_line;
        next_rdata    = rdata;
        if (reg_wr_i && reg_addr_i == TUNE_REG_OFFSET)
            next_tune_reg = reg_wdata_i;
        if (reg_wr_i && reg_addr_i == IRQ_REG_OFFSET)
            next_irq_reg[7:4] = reg_wdata_i[7:4];
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                TUNE_REG_OFFSET: next_rdata = tune_reg;
                IRQ_REG_OFFSET:  next_rdata = irq_reg;
                default:         next_rdata = 8'h00;
            endcase
            if (reg_addr_i == IRQ_REG_OFFSET)
                next_irq_line = 1'b0;
        end
        // A new event wins over the clear by read
        if (irq_event_i)
        begin
            next_irq_reg[3:0] = irq_cause_i;
            next_irq_line     = 1'b1;
        end
        next_sys_div = ~sys_div;
        unique case (disp)
            DISP_ANT:  next_pin = div_bus.div_out;
            DISP_SYS:  next_pin = next_sys_div;
            DISP_TMR:  next_pin = tmr_osc_i;
            DISP_NONE: next_pin = next_irq_line;
        endcase
    end

    // Calibration: count both oscillators over a fixed span of antenna cycles
    always_comb
    begin
        next_cal_st   = cal_st;
        next_ant_cnt  = ant_cnt;
        next_sys_cnt  = sys_cnt;
        next_tmr_cnt  = tmr_cnt;
        next_sys_trim = sys_trim;
        next_tmr_trim = tmr_trim;
        unique case (cal_st)
            CAL_IDLE:
            begin
                if (calib_cmd_i)
                begin
                    next_cal_st  = CAL_MEASURE;
                    next_ant_cnt = '0;
                    next_sys_cnt = '0;
                    next_tmr_cnt = '0;
                end
            end
            CAL_MEASURE:
            begin
                next_sys_cnt = sys_cnt + CNT_W'(1);
                if (tmr_rise)
                    next_tmr_cnt = tmr_cnt + CNT_W'(1);
                if (ant_edge_i)
                    next_ant_cnt = ant_cnt + CNT_W'(1);
                if (ant_cnt == CNT_W'(CAL_WINDOW_ANT))
                    next_cal_st = CAL_DONE;
            end
            CAL_DONE:
            begin
                // One trim step toward nominal; a slow oscillator gets a faster code
                if (sys_cnt < CNT_W'(SYS_PER_WINDOW) && sys_trim != '1)
                    next_sys_trim = sys_trim + TRIM_W'(1);
                else if (sys_cnt > CNT_W'(SYS_PER_WINDOW) && sys_trim != '0)
                    next_sys_trim = sys_trim - TRIM_W'(1);
                if (tmr_cnt < CNT_W'(TMR_PER_WINDOW) && tmr_trim != '1)
                    next_tmr_trim = tmr_trim + TRIM_W'(1);
                else if (tmr_cnt > CNT_W'(TMR_PER_WINDOW) && tmr_trim != '0)
                    next_tmr_trim = tmr_trim - TRIM_W'(1);
                next_cal_st = CAL_IDLE;
            end
            default: next_cal_st = CAL_IDLE;
        endcase
        // Busy is registered so the output comes straight from a flop
        next_busy = (next_cal_st != CAL_IDLE);
    end

    // Trim lives only in flops: reset restores the midpoint code
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tune_reg <= TUNE_REG_RESET;
            irq_reg  <= IRQ_REG_RESET;
            irq_line <= 1'b0;
            rdata    <= 8'h00;
            pin      <= 1'b0;
            sys_div  <= 1'b0;
            tmr_q    <= 1'b0;
            cal_st   <= CAL_IDLE;
            ant_cnt  <= '0;
            sys_cnt  <= '0;
            tmr_cnt  <= '0;
            sys_trim <= TRIM_RESET;
            tmr_trim <= TRIM_RESET;
            busy     <= 1'b0;
        end
        else
        begin
            tune_reg <= next_tune_reg;
            irq_reg  <= next_irq_reg;
            irq_line <= next_irq_line;
            rdata    <= next_rdata;
            pin      <= next_pin;
            sys_div  <= next_sys_div;
            tmr_q    <= tmr_osc_i;
            cal_st   <= next_cal_st;
            ant_cnt  <= next_ant_cnt;
            sys_cnt  <= next_sys_cnt;
            tmr_cnt  <= next_tmr_cnt;
            sys_trim <= next_sys_trim;
            tmr_trim <= next_tmr_trim;
            busy     <= next_busy;
        end
    end

    assign reg_rdata_o = rdata;
    assign cap_sel_o   = tune_reg[CAP_MSB:0];
    assign irq_o       = pin;
    assign sys_trim_o  = sys_trim;
    assign tmr_trim_o  = tmr_trim;
    assign cal_busy_o  = busy;

    cap_follow_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (reg_wr_i && reg_addr_i == TUNE_REG_OFFSET) |=> cap_sel_o == $past(reg_wdata_i[3:0]))
        else $error("capacitor field not applied");
    ant_display_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        tune_reg[ANT_DISP_BIT] |=> irq_o == $past(div_bus.div_out))
        else $error("antenna display missing");
    sys_display_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (!tune_reg[ANT_DISP_BIT] && tune_reg[SYS_DISP_BIT] && $stable(tune_reg))
        |=> irq_o != $past(irq_o))
        else $error("system clock display stalled");
    tmr_display_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (tune_reg[7:5] == 3'b001) |=> irq_o == $past(tmr_osc_i))
        else $error("timer display wrong");
    irq_only_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (tune_reg[7:5] == 3'b000) |=> irq_o == irq_line)
        else $error("pin not carrying interrupt");
    irq_set_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        irq_event_i |=> irq_line && irq_reg[3:0] == $past(irq_cause_i))
        else $error("interrupt event lost");
    cal_start_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (cal_st == CAL_IDLE && calib_cmd_i) |=> cal_busy_o ##0 sys_cnt == '0)
        else $error("calibration did not start");
    trim_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (cal_st != CAL_DONE) |=> $stable(sys_trim) && $stable(tmr_trim))
        else $error("trim changed outside calibration");
    sys_clock_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        sys_div |=> !sys_div)
        else $error("system clock divider stuck");
endmodule

// ---- rtl/tune_cal_if.sv ----
// Carrier from top to the divider: antenna input, ratio and output
`timescale 1ns/1ps
interface tune_cal_if;
    logic       ant_edge;
    logic [1:0] ratio_sel;
    logic       div_out;
    logic       div_pulse;
    modport top (output ant_edge, output ratio_sel, input div_out, input div_pulse);
    modport div (input ant_edge, input ratio_sel, output div_out, output div_pulse);
endinterface

// ---- rtl/tune_cal_pkg.sv ----
// Constants for antenna tuning, clock display and oscillator calibration
package tune_cal_pkg;
    localparam logic [7:0] TUNE_REG_OFFSET   = 8'h08;
    localparam logic [7:0] IRQ_REG_OFFSET    = 8'h03;
    localparam int         ANT_DISP_BIT      = 7;
    localparam int         SYS_DISP_BIT      = 6;
    localparam int         TMR_DISP_BIT      = 5;
    localparam int         CAP_MSB           = 3;
    localparam int         DIV_SEL_MSB       = 7;
    localparam int         DIV_SEL_LSB       = 6;
    localparam logic [7:0] TUNE_REG_RESET    = 8'h00;
    localparam logic [7:0] IRQ_REG_RESET     = 8'h00;
    localparam int         TRIM_W            = 8;
    localparam logic [7:0] TRIM_RESET        = 8'h80;
    localparam int         CAL_WINDOW_ANT    = 64;
    localparam int         SYS_OSC_KHZ       = 1100;
    localparam int         TMR_OSC_HZ        = 32768;
    localparam int         ANT_TARGET_KHZ    = 500;
    localparam int         SYS_PER_WINDOW    = (CAL_WINDOW_ANT * SYS_OSC_KHZ) / ANT_TARGET_KHZ;
    localparam int         TMR_PER_WINDOW    = (CAL_WINDOW_ANT * TMR_OSC_HZ) / (ANT_TARGET_KHZ * 1000);
    typedef enum logic [1:0] {DISP_NONE, DISP_ANT, DISP_SYS, DISP_TMR} disp_sel_e;
    typedef enum logic [1:0] {CAL_IDLE, CAL_MEASURE, CAL_DONE} cal_state_e;
endpackage

// ---- testbench/osc_partner.sv ----
// Model of the antenna resonance and timer oscillator seen by the block
`timescale 1ns/1ps
module osc_partner #(
    parameter int ANT_PER  = 2,
    parameter int TMR_HALF = 4
)(
    input  wire logic ref_clk_i,
    output logic      ant_edge_o,
    output logic      tmr_osc_o
);
    int ant_cnt = 0;
    int tmr_cnt = 0;
    initial ant_edge_o = 1'b0;
    initial tmr_osc_o  = 1'b0;
    // Resonator and oscillator run free, reset of the block does not stop them
    always @(posedge ref_clk_i)
    begin
        #1;
        ant_cnt    = (ant_cnt + 1) % ANT_PER;
        ant_edge_o = (ant_cnt == 0);
        tmr_cnt    = (tmr_cnt + 1) % TMR_HALF;
        if (tmr_cnt == 0)
            tmr_osc_o = ~tmr_osc_o;
    end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the tuning, clock display and trim block
`timescale 1ns/1ps
module testbench
    import tune_cal_pkg::*;
;
    logic        ref_clk_i   = 1'b0;
    logic        nrst_i      = 1'b0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        calib_cmd_i = 1'b0;
    logic        irq_event_i = 1'b0;
    logic [3:0]  irq_cause_i = 4'h0;
    logic        ant_edge;
    logic        tmr_osc;
    logic [7:0]  reg_rdata_o;
    logic [3:0]  cap_sel_o;
    logic        irq_o;
    logic [7:0]  sys_trim_o;
    logic [7:0]  tmr_trim_o;
    logic        cal_busy_o;
    logic [7:0]  d;
    int          n_mismatch  = 0;
    int          checked     = 0;
    int          cycles      = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    tune_cal_ctrl u_tune_cal_ctrl (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .calib_cmd_i(calib_cmd_i), .ant_edge_i(ant_edge), .tmr_osc_i(tmr_osc),
        .irq_event_i(irq_event_i), .irq_cause_i(irq_cause_i), .reg_rdata_o(reg_rdata_o),
        .cap_sel_o(cap_sel_o), .irq_o(irq_o), .sys_trim_o(sys_trim_o),
        .tmr_trim_o(tmr_trim_o), .cal_busy_o(cal_busy_o));

    osc_partner u_osc_partner (.ref_clk_i(ref_clk_i), .ant_edge_o(ant_edge),
        .tmr_osc_o(tmr_osc));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        tick();
        reg_wr_i    = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = v;
        tick();
        reg_wr_i    = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        tick();
        reg_rd_i   = 1'b1;
        reg_addr_i = a;
        tick();
        reg_rd_i   = 1'b0;
        v          = reg_rdata_o;
    endtask

    task automatic calib();
        tick();
        calib_cmd_i = 1'b1;
        tick();
        calib_cmd_i = 1'b0;
    endtask

    task automatic wait_lvl(input logic v, inout int n);
        int k;
        k = 0;
        while (irq_o !== v && k < 400)
        begin
            tick();
            n++;
            k++;
        end
    endtask

    // Syncs to one rising edge of the pin, then counts cycles to the next
    task automatic per_chk(input int exp, input string what);
        int n;
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        chk(n[15:0], exp[15:0], what);
    endtask

    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            $display("[FAIL] %0t run timed out", $time);
            wrap_up();
        end
    end

    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        rd(TUNE_REG_OFFSET, d);
        chk(d, TUNE_REG_RESET, "tune reset");
        rd(IRQ_REG_OFFSET, d);
        chk(d, IRQ_REG_RESET, "irq reset");
        rd(8'h10, d);
        chk(d, 8'h00, "unmapped read");
        chk(sys_trim_o, TRIM_RESET, "sys trim reset");
        chk(irq_o, 1'b0, "pin idle");
        $display("test reset done");
        wr(TUNE_REG_OFFSET, 8'h0A);
        chk(cap_sel_o, 4'hA, "cap select");
        rd(TUNE_REG_OFFSET, d);
        chk(d, 8'h0A, "tune readback");
        $display("test capacitors done");
        // Antenna pulse every 2 cycles, so a display period is ratio times 2
        for (int r = 0; r < 4; r++)
        begin
            wr(IRQ_REG_OFFSET, 8'(r << 6));
            wr(TUNE_REG_OFFSET, 8'h8A);
            per_chk((16 << r) * 2, "antenna period");
        end
        wr(TUNE_REG_OFFSET, 8'h40);
        per_chk(2, "system display");
        wr(TUNE_REG_OFFSET, 8'h20);
        per_chk(8, "timer display");
        $display("test display done");
        wr(TUNE_REG_OFFSET, 8'h0A);
        tick();
        irq_event_i = 1'b1;
        irq_cause_i = 4'h8;
        tick();
        irq_event_i = 1'b0;
        tick();
        chk(irq_o, 1'b1, "event raises pin");
        rd(IRQ_REG_OFFSET, d);
        chk(d[3:0], 4'h8, "cause code");
        tick();
        tick();
        chk(irq_o, 1'b0, "read clears pin");
        $display("test interrupt done");
        // Antenna already tuned above before trimming the oscillators
        calib();
        chk(cal_busy_o, 1'b1, "calibration busy");
        calib();
        for (int k = 0; k < 400 && cal_busy_o !== 1'b0; k++)
            tick();
        chk(cal_busy_o, 1'b0, "calibration ends");
        chk(sys_trim_o === TRIM_RESET + 8'h01 || sys_trim_o === TRIM_RESET - 8'h01,
            1'b1, "sys trim one step");
        chk(tmr_trim_o === TRIM_RESET + 8'h01 || tmr_trim_o === TRIM_RESET - 8'h01,
            1'b1, "tmr trim one step");
        $display("test calibration done");
        // Recalibration of both oscillators: command, timer display bit set, short wait, bit cleared
        calib();
        wr(TUNE_REG_OFFSET, 8'h20);
        repeat (300) tick();
        wr(TUNE_REG_OFFSET, 8'h00);
        tick();
        tick();
        chk(irq_o, 1'b0, "display off");
        nrst_i = 1'b0;
        repeat (2) tick();
        nrst_i = 1'b1;
        chk(sys_trim_o, TRIM_RESET, "sys trim lost");
        chk(tmr_trim_o, TRIM_RESET, "tmr trim lost");
        $display("test reset of trims done");
        wrap_up();
    end
endmodule
